// ===== src/lpc_dev.sv
// sensor device register bank, persistence filters and open-low event pin
// assumes converter results arrive as one-cycle strobes from the analog side
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "lpc_params.svh"

// Operation
// - offset zero reserved, reads zero, no function
// - bit7 enables distance, first result after 0.54ms
// - idle codes 111/110/101/100: 0/12.5/50/75ms
// - idle codes 011/010/001/000: 100/200/400/800ms
// - bit3 selects 110mA or 220mA drive
// - bit2 enables light, result every 100ms
// - bit1 selects low or high lux range
// - bit0 selects visible or infrared data
// - distance flag set by event, cleared by zero
// - distance persistence 1/4/8/16 results
// - host writes bit4 as zero
// - light flag set by event, cleared by zero
// - light persistence 1/4/8/16 results
// - event pin OR or AND of flags
// - distance low limit resets 0x00
// - distance high limit resets 0xff
// - light low limit low byte resets 0x00
// - offset six splits light limit nibbles
// - offset seven light high upper byte
module lpc_dev #(
  parameter int unsigned DCONV_CYC = `LPC_DCONV_CYC,
  parameter int unsigned LCONV_CYC = `LPC_LCONV_CYC,
  parameter int unsigned IDLE_DIV  = 1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register link
  lpc_if.dev               bus,
  // converter results
  input  wire logic        dist_valid,
  input  wire logic [7:0]  dist_result,
  input  wire logic        light_valid,
  input  wire logic [11:0] light_result,
  // analog controls
  output logic             dist_start,
  output logic             light_start,
  output logic             emitter_current_select,
  output logic             light_gain_select,
  output logic             spectrum_select
);

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  evt;
    logic [7:0]  dlo;
    logic [7:0]  dhi;
    logic [7:0]  llo0;
    logic [7:0]  lth2;
    logic [7:0]  lth3;
    logic [7:0]  rdata;
    logic        pin_low;
    logic [3:0]  dcnt;
    logic [3:0]  lcnt;
    logic [31:0] dtim;
    logic [31:0] ltim;
    logic        dstart;
    logic        lstart;
  } lpc_dev_st_t;

  lpc_dev_st_t st_ff;
  lpc_dev_st_t nxt_st;

  logic [11:0] light_low_limit;
  logic [11:0] light_high_limit;
  logic        dist_trip;
  logic        light_trip;
  logic [3:0]  dneed;
  logic [3:0]  lneed;
  logic [31:0] idle_cyc;

  function automatic logic [3:0] persist_last(input logic [1:0] code);
    case (code)
      2'b00:   persist_last = 4'h0;
      2'b01:   persist_last = 4'h3;
      2'b10:   persist_last = 4'h7;
      default: persist_last = 4'hf;
    endcase
  endfunction

  function automatic logic [31:0] idle_us(input logic [2:0] code);
    case (code)
      3'b000:  idle_us = 32'(`LPC_IDLE_US_0);
      3'b001:  idle_us = 32'(`LPC_IDLE_US_1);
      3'b010:  idle_us = 32'(`LPC_IDLE_US_2);
      3'b011:  idle_us = 32'(`LPC_IDLE_US_3);
      3'b100:  idle_us = 32'(`LPC_IDLE_US_4);
      3'b101:  idle_us = 32'(`LPC_IDLE_US_5);
      3'b110:  idle_us = 32'(`LPC_IDLE_US_6);
      default: idle_us = 32'(`LPC_IDLE_US_7);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // light limit nibbles
  assign light_low_limit  = {st_ff.lth2[3:0], st_ff.llo0};
  assign light_high_limit = {st_ff.lth3, st_ff.lth2[7:4]};
  // distance trips above high limit; low limit kept for software hysteresis
  assign dist_trip  = dist_result > st_ff.dhi;
  assign light_trip = (light_result < light_low_limit) || (light_result > light_high_limit);
  assign dneed = persist_last(st_ff.evt[`LPC_EVT_DPER_HI:`LPC_EVT_DPER_LO]);
  assign lneed = persist_last(st_ff.evt[`LPC_EVT_LPER_HI:`LPC_EVT_LPER_LO]);
  assign idle_cyc = 32'((idle_us(st_ff.cfg[`LPC_CFG_IDLE_HI:`LPC_CFG_IDLE_LO])
                         * `LPC_CLK_PER_US) / IDLE_DIV);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dstart = 1'b0;
    nxt_st.lstart = 1'b0;
    nxt_st.rdata  = 8'h00;
    // register reads, answer next cycle
    if (bus.rd) begin
      case (bus.addr)
        `LPC_ADDR_RSVD: nxt_st.rdata = 8'h00;
        `LPC_ADDR_CFG:  nxt_st.rdata = st_ff.cfg;
        `LPC_ADDR_EVT:  nxt_st.rdata = st_ff.evt;
        `LPC_ADDR_DLO:  nxt_st.rdata = st_ff.dlo;
        `LPC_ADDR_DHI:  nxt_st.rdata = st_ff.dhi;
        `LPC_ADDR_LLO0: nxt_st.rdata = st_ff.llo0;
        `LPC_ADDR_LTH2: nxt_st.rdata = st_ff.lth2;
        `LPC_ADDR_LTH3: nxt_st.rdata = st_ff.lth3;
        default:        nxt_st.rdata = 8'h00;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        `LPC_ADDR_CFG: begin
          nxt_st.cfg = bus.wdata;
          if (bus.wdata[`LPC_CFG_DEN] && !st_ff.cfg[`LPC_CFG_DEN]) nxt_st.dtim = 32'h0;
          if (bus.wdata[`LPC_CFG_LEN] && !st_ff.cfg[`LPC_CFG_LEN]) nxt_st.ltim = 32'h0;
        end
        `LPC_ADDR_EVT: begin
          // flags only clear by writing zero; bit4 held zero
          nxt_st.evt = {bus.wdata[7] & st_ff.evt[7], bus.wdata[6:5], 1'b0,
                        bus.wdata[3] & st_ff.evt[3], bus.wdata[2:0]};
        end
        `LPC_ADDR_DLO:  nxt_st.dlo  = bus.wdata;
        `LPC_ADDR_DHI:  nxt_st.dhi  = bus.wdata;
        `LPC_ADDR_LLO0: nxt_st.llo0 = bus.wdata;
        `LPC_ADDR_LTH2: nxt_st.lth2 = bus.wdata;
        `LPC_ADDR_LTH3: nxt_st.lth3 = bus.wdata;
        default: ;
      endcase
    end
    if (st_ff.cfg[`LPC_CFG_DEN] && !(bus.wr && bus.addr == `LPC_ADDR_CFG)) begin
      if (st_ff.dtim >= 32'(DCONV_CYC) - 32'h1 + idle_cyc) begin
        nxt_st.dtim   = 32'h0;
      end else begin
        nxt_st.dtim   = st_ff.dtim + 32'h1;
      end
      if (st_ff.dtim == 32'h0) nxt_st.dstart = 1'b1;
    end
    if (st_ff.cfg[`LPC_CFG_LEN] && !(bus.wr && bus.addr == `LPC_ADDR_CFG)) begin
      nxt_st.ltim = (st_ff.ltim >= 32'(LCONV_CYC) - 32'h1) ? 32'h0 : st_ff.ltim + 32'h1;
      if (st_ff.ltim == 32'h0) nxt_st.lstart = 1'b1;
    end
    if (dist_valid && st_ff.cfg[`LPC_CFG_DEN]) begin
      if (!dist_trip) begin
        nxt_st.dcnt = 4'h0;
      end else if (st_ff.dcnt >= dneed) begin
        nxt_st.evt[`LPC_EVT_DFLAG] = 1'b1;
        nxt_st.dcnt = 4'h0;
      end else begin
        nxt_st.dcnt = st_ff.dcnt + 4'h1;
      end
    end
    if (light_valid && st_ff.cfg[`LPC_CFG_LEN]) begin
      if (!light_trip) begin
        nxt_st.lcnt = 4'h0;
      end else if (st_ff.lcnt >= lneed) begin
        nxt_st.evt[`LPC_EVT_LFLAG] = 1'b1;
        nxt_st.lcnt = 4'h0;
      end else begin
        nxt_st.lcnt = st_ff.lcnt + 4'h1;
      end
    end
    nxt_st.pin_low = nxt_st.evt[`LPC_EVT_AND]
                   ? (nxt_st.evt[`LPC_EVT_DFLAG] & nxt_st.evt[`LPC_EVT_LFLAG])
                   : (nxt_st.evt[`LPC_EVT_DFLAG] | nxt_st.evt[`LPC_EVT_LFLAG]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.cfg   <= `LPC_RST_CFG;
      st_ff.evt   <= `LPC_RST_EVT;
      st_ff.dlo   <= `LPC_RST_DLO;
      st_ff.dhi   <= `LPC_RST_DHI;
      st_ff.llo0  <= `LPC_RST_LLO0;
      st_ff.lth2  <= `LPC_RST_LTH2;
      st_ff.lth3  <= `LPC_RST_LTH3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-low pin: drive low only, never high
  assign bus.rdata              = st_ff.rdata;
  assign bus.event_n_o          = 1'b0;
  assign bus.event_n_oe         = st_ff.pin_low;
  assign dist_start             = st_ff.dstart;
  assign light_start            = st_ff.lstart;
  assign emitter_current_select = st_ff.cfg[`LPC_CFG_DRIVE];
  assign light_gain_select      = st_ff.cfg[`LPC_CFG_GAIN];
  assign spectrum_select        = st_ff.cfg[`LPC_CFG_SPEC];

endmodule

// ===== src/lpc_host.sv
// host controller: one register access per command, reports event pin
// assumes the device answers reads one cycle after the read strobe
`timescale 1ns/1ps
`include "lpc_params.svh"

module lpc_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register link
  lpc_if.host             bus,
  // user command port
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [3:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            event_active
);

  typedef struct packed {
    lpc_pkg::lpc_hstate_t state;
    logic [3:0]           addr;
    logic [7:0]           wdata;
    logic                 wr;
    logic                 rd;
    logic                 rsp_valid;
    logic [7:0]           rsp_rdata;
    logic                 evt;
    logic                 rdy;
  } lpc_host_st_t;

  lpc_host_st_t st_ff;
  lpc_host_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.evt = bus.event_n_oe;
    case (st_ff.state)
      lpc_pkg::LPC_H_IDLE: begin
        if (cmd_valid) begin
          nxt_st.addr  = cmd_addr;
          // bit4 of event register written zero
          nxt_st.wdata = (cmd_addr == `LPC_ADDR_EVT)
                         ? (cmd_wdata & ~(8'h01 << `LPC_EVT_ZERO)) : cmd_wdata;
          nxt_st.wr    = cmd_write;
          nxt_st.rd    = !cmd_write;
          nxt_st.state = cmd_write ? lpc_pkg::LPC_H_DONE : lpc_pkg::LPC_H_WAIT;
        end
      end
      lpc_pkg::LPC_H_WAIT: begin
        nxt_st.state = lpc_pkg::LPC_H_DONE;
      end
      lpc_pkg::LPC_H_DONE: begin
        if (st_ff.rd == 1'b0 && st_ff.wr == 1'b0) begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_rdata = bus.rdata;
        end
        nxt_st.state = lpc_pkg::LPC_H_IDLE;
      end
      default: nxt_st.state = lpc_pkg::LPC_H_IDLE;
    endcase
    // ready registered so the port comes straight from a flop
    nxt_st.rdy = (nxt_st.state == lpc_pkg::LPC_H_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.state <= lpc_pkg::LPC_H_IDLE;
      st_ff.rdy   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready only in idle; one command outstanding keeps the link simple
  assign cmd_ready    = st_ff.rdy;
  assign bus.addr     = st_ff.addr;
  assign bus.wdata    = st_ff.wdata;
  assign bus.wr       = st_ff.wr;
  assign bus.rd       = st_ff.rd;
  assign rsp_valid    = st_ff.rsp_valid;
  assign rsp_rdata    = st_ff.rsp_rdata;
  assign event_active = st_ff.evt;

endmodule

// ===== src/lpc_if.sv
// register access link between host controller and sensor device
// assumes one shared clock; read data answers one cycle after rd
`timescale 1ns/1ps
interface lpc_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       event_n_o;
  logic       event_n_oe;

  modport dev  (input addr, wdata, wr, rd, output rdata, event_n_o, event_n_oe);
  modport host (output addr, wdata, wr, rd, input rdata, event_n_o, event_n_oe);
endinterface

// ===== src/lpc_params.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

`define LPC_ADDR_RSVD      4'h0
`define LPC_ADDR_CFG       4'h1
`define LPC_ADDR_EVT       4'h2
`define LPC_ADDR_DLO       4'h3
`define LPC_ADDR_DHI       4'h4
`define LPC_ADDR_LLO0      4'h5
`define LPC_ADDR_LTH2      4'h6
`define LPC_ADDR_LTH3      4'h7

`define LPC_RST_CFG        8'h00
`define LPC_RST_EVT        8'h00
`define LPC_RST_DLO        8'h00
`define LPC_RST_DHI        8'hff
`define LPC_RST_LLO0       8'h00
`define LPC_RST_LTH2       8'hf0
`define LPC_RST_LTH3       8'hff

`define LPC_CFG_DEN        7
`define LPC_CFG_IDLE_HI    6
`define LPC_CFG_IDLE_LO    4
`define LPC_CFG_DRIVE      3
`define LPC_CFG_LEN        2
`define LPC_CFG_GAIN       1
`define LPC_CFG_SPEC       0

`define LPC_EVT_DFLAG      7
`define LPC_EVT_DPER_HI    6
`define LPC_EVT_DPER_LO    5
`define LPC_EVT_ZERO       4
`define LPC_EVT_LFLAG      3
`define LPC_EVT_LPER_HI    2
`define LPC_EVT_LPER_LO    1
`define LPC_EVT_AND        0

// times in microseconds, cycles at 50 per microsecond
`define LPC_CLK_PER_US     50
`define LPC_DCONV_US       540
`define LPC_LCONV_US       100000
`define LPC_DCONV_CYC      (`LPC_DCONV_US * `LPC_CLK_PER_US)
`define LPC_LCONV_CYC      (`LPC_LCONV_US * `LPC_CLK_PER_US)
`define LPC_IDLE_US_0      800000
`define LPC_IDLE_US_1      400000
`define LPC_IDLE_US_2      200000
`define LPC_IDLE_US_3      100000
`define LPC_IDLE_US_4      75000
`define LPC_IDLE_US_5      50000
`define LPC_IDLE_US_6      12500
`define LPC_IDLE_US_7      0

`endif

// ===== src/lpc_pkg.sv
// types for the host end of the sensor register link; the device uses none of them
// assumes lpc_params.svh for numbers
package lpc_pkg;
  typedef logic [3:0] lpc_addr_t;
  typedef logic [7:0] lpc_byte_t;
  typedef enum logic [1:0] {
    LPC_H_IDLE = 2'b00,
    LPC_H_WAIT = 2'b01,
    LPC_H_DONE = 2'b10
  } lpc_hstate_t;
endpackage

// ===== test/lpc_monitor.sv
// checker on the link signals between host controller and sensor device
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module lpc_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link signals
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       event_n_o,
  input wire logic       event_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of what was written; flag bits are masked off where compared
  logic [7:0] shd_ff [8];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shd_ff <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff};
    end else if (wr && !addr[3]) begin
      shd_ff[addr[2:0]] <= wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_rsvd_reads_zero:
    assert property (rd && addr == 4'h0 |=> rdata == 8'h00) else $error("reserved index nonzero");
  chk_unmapped_zero:
    assert property (rd && addr[3] |=> rdata == 8'h00) else $error("unmapped index nonzero");
  chk_unused_bit_zero:
    assert property (rd && addr == 4'h2 |=> !rdata[4]) else $error("event bit4 set");
  chk_pin_only_low:
    assert property (event_n_o == 1'b0) else $error("event pin driven high");
  chk_cfg_readback:
    assert property (rd && addr == 4'h1 |=> rdata == shd_ff[1]) else $error("config readback");
  chk_evt_ctrl_back:
    assert property (rd && addr == 4'h2 |=> (rdata & 8'h67) == (shd_ff[2] & 8'h67))
      else $error("event control readback");
  chk_dist_low_back:
    assert property (rd && addr == 4'h3 |=> rdata == shd_ff[3]) else $error("low limit readback");
  chk_dist_high_back:
    assert property (rd && addr == 4'h4 |=> rdata == shd_ff[4]) else $error("high limit readback");
  chk_light_low_back:
    assert property (rd && addr == 4'h5 |=> rdata == shd_ff[5]) else $error("light low readback");
  chk_light_mid_back:
    assert property (rd && addr == 4'h6 |=> rdata == shd_ff[6]) else $error("light mid readback");
  chk_light_top_back:
    assert property (rd && addr == 4'h7 |=> rdata == shd_ff[7]) else $error("light top readback");
endmodule

// ===== test/tb_light_proximity_config_interrupt_regs.sv
// bench: host and device joined by the link, driven from the host command port
// assumes converter results are single-cycle strobes from the bench
`timescale 1ns/1ps
module tb_light_proximity_config_interrupt_regs;
  localparam int DCONV = 20;
  localparam int LCONV = 100;
  // idle divider large enough that every idle code fits in a short run
  localparam int IDIV  = 10000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [3:0]  cmd_addr = 4'h0;
  logic [7:0]  cmd_wdata = 8'h00;
  logic        dist_valid = 1'b0;
  logic [7:0]  dist_result = 8'h00;
  logic        light_valid = 1'b0;
  logic [11:0] light_result = 12'h000;
  logic        cmd_ready, rsp_valid, event_active, dist_start, light_start;
  logic        emitter_current_select, light_gain_select, spectrum_select;
  logic [7:0]  rsp_rdata, rdv;
  int          err_total = 0;
  int          tests_run = 0;
  lpc_if link ();
  lpc_host u_lpc_host (.clk(clk), .rst(rst), .bus(link), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .event_active(event_active));
  lpc_dev #(.DCONV_CYC(DCONV), .LCONV_CYC(LCONV), .IDLE_DIV(IDIV)) u_lpc_dev (.clk(clk),
    .rst(rst), .bus(link), .dist_valid(dist_valid), .dist_result(dist_result),
    .light_valid(light_valid), .light_result(light_result), .dist_start(dist_start),
    .light_start(light_start), .emitter_current_select(emitter_current_select),
    .light_gain_select(light_gain_select), .spectrum_select(spectrum_select));
  lpc_monitor u_lpc_monitor (.clk(clk), .rst(rst), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .event_n_o(link.event_n_o),
    .event_n_oe(link.event_n_oe));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command; reads leave their answer in rdv, unknown if none came
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    for (int n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    rdv = 8'hxx;
    for (int n = 0; n < 20 && !w && rsp_valid !== 1'b1; n++) @(negedge clk);
    if (!w && rsp_valid === 1'b1) rdv = rsp_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, rdv}, {8'h00, e});
  endtask
  task automatic ev(input logic l, input logic [11:0] v);
    @(posedge clk);
    if (l) begin
      light_valid  <= 1'b1;
      light_result <= v;
    end else begin
      dist_valid  <= 1'b1;
      dist_result <= v[7:0];
    end
    @(posedge clk);
    light_valid <= 1'b0;
    dist_valid  <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rchk(4'(i < 8 ? i : i + 6), rv[i]);
    acc(1'b1, 4'h0, 8'h5a);
    acc(1'b1, 4'hf, 8'h5a);
    rchk(4'h0, 8'h00);
    rchk(4'hf, 8'h00);
    for (int i = 3; i < 8; i++) acc(1'b1, 4'(i), 8'(8'ha0 + i));
    for (int i = 3; i < 8; i++) rchk(4'(i), 8'(8'ha0 + i));
  endtask
  task automatic t_cfg();
    logic [7:0] cv [3] = '{8'h08, 8'h02, 8'h01};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 4'h1, cv[i]);
      rchk(4'h1, cv[i]);
      chk({13'h0000, emitter_current_select, light_gain_select, spectrum_select},
        {13'h0000, cv[i][3], cv[i][1:0]});
    end
  endtask
  // distance pulse spacing per idle code, light spacing fixed
  task automatic gap(input logic l, output logic [15:0] n);
    n = 16'h0000;
    @(negedge clk);
    for (int i = 0; i < 6000 && (l ? light_start : dist_start) !== 1'b1; i++) @(negedge clk);
    do begin
      @(negedge clk);
      n++;
    end while ((l ? light_start : dist_start) !== 1'b1 && n < 16'h3000);
  endtask
  task automatic t_gap();
    logic [15:0] n;
    int          us [8] = '{800000, 400000, 200000, 100000, 75000, 50000, 12500, 0};
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 4'h1, 8'h04);
      acc(1'b1, 4'h1, {1'b1, 3'(c), 4'h4});
      gap(1'b0, n);
      // 50 cycles per microsecond at the bench clock
      chk(n, 16'(DCONV + us[c] * 50 / IDIV));
    end
    gap(1'b1, n);
    chk(n, 16'(LCONV));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_persist(input logic l);
    logic [15:0] nn;
    logic [7:0]  ct;
    logic [7:0]  fl;
    fl = l ? 8'h08 : 8'h80;
    for (int c = 0; c < 4; c++) begin
      nn = (c == 0) ? 16'h0001 : 16'h0004 << (c - 1);
      ct = l ? {5'h00, 2'(c), 1'b0} : {1'b0, 2'(c), 5'h00};
      acc(1'b1, 4'h2, ct);
      for (int k = 1; k < nn; k++) ev(l, l ? 12'h300 : 12'h0c0);
      ev(l, l ? 12'h150 : 12'h040);
      for (int k = 1; k < nn; k++) ev(l, l ? 12'h300 : 12'h0c0);
      rchk(4'h2, ct);
      ev(l, l ? 12'h300 : 12'h0c0);
      rchk(4'h2, ct | fl);
      chk({15'h0000, event_active}, 16'h0001);
      acc(1'b1, 4'h2, ct);
      rchk(4'h2, ct);
      chk({15'h0000, event_active}, 16'h0000);
    end
  endtask
  task automatic t_and();
    acc(1'b1, 4'h2, 8'h11);
    rchk(4'h2, 8'h01);
    ev(1'b0, 12'h0c0);
    rchk(4'h2, 8'h81);
    chk({15'h0000, event_active}, 16'h0000);
    ev(1'b1, 12'h005);
    rchk(4'h2, 8'h89);
    chk({15'h0000, event_active}, 16'h0001);
    acc(1'b1, 4'h2, 8'h01);
    rchk(4'h2, 8'h01);
    chk({15'h0000, event_active}, 16'h0000);
  endtask
  // mid-run reset with a flag up and both engines running
  task automatic t_reset();
    logic [7:0] dv [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff};
    acc(1'b1, 4'h2, 8'h00);
    acc(1'b1, 4'h1, 8'h87);
    ev(1'b0, 12'h0c0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({10'h000, cmd_ready, dist_start, light_start, event_active, light_gain_select,
      spectrum_select}, 16'h0020);
    for (int i = 1; i < 8; i++) rchk(4'(i), dv[i - 1]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cfg();
    t_gap();
    acc(1'b1, 4'h1, 8'h84);
    acc(1'b1, 4'h4, 8'h80);
    acc(1'b1, 4'h5, 8'h10);
    acc(1'b1, 4'h6, 8'h81);
    acc(1'b1, 4'h7, 8'h20);
    t_persist(1'b0);
    t_persist(1'b1);
    t_and();
    t_reset();
    test_done();
  end
endmodule
